// >>> hw/usp_defs.vh
// Constants for the serial port: addresses, control bit positions, modes and timing.
// Contract
// [R1] Transmitter and receiver run fully independently; in shift mode the code makes each wait for the other to go idle.
// [R2] Receive is double buffered behind shifter.
// [R3] Unread held character is overwritten, lost.
// [R4] One data address: write transmit, read receive.
// [R5] Control register at own address, resets zero.
// [R6] Bits 7:6 pick one of four modes.
// [R7] Shift-register mode shifts at clock/2.
// [R8] Fixed 9-bit mode: clock/32, or /16 doubled.
// [R9] Variable modes use external rate tick.
// [R10] Control bit 5 enables multiprocessor filtering.
// [R11] 8-bit multiprocessor mode needs valid stop bit.
// [R12] 9-bit multiprocessor mode needs ninth bit one.
// [R13] Filtering off: every character raises receive flag.
// [R14] Control bit 4 enables the receiver.
// [R15] Transmit flag at eighth bit or stop start.
// [R16] Receive flag at eighth bit or mid-stop; in shift mode the code sets it two clocks after the eighth bit.
// [R17] Ninth bit, or mode 1 stop, latched.
// [R18] Reception starts per mode on enable conditions.
// [R19] Serial lines idle high; falling edge starts.
`ifndef USP_DEFS_VH
`define USP_DEFS_VH

// Register addresses.
`define USP_ADDR_CTRL      8'h98
`define USP_ADDR_DATA      8'h99
`define USP_CTRL_RESET     8'h00

// Control register bit positions.
`define USP_BIT_MODE_HI    7
`define USP_BIT_MODE_LO    6
`define USP_BIT_MPEN       5
`define USP_BIT_REN        4
`define USP_BIT_TXNINE     3
`define USP_BIT_RXNINE     2
`define USP_BIT_TXDONE     1
`define USP_BIT_RXDONE     0

// Mode field encodings.
`define USP_MODE_SHIFT     2'h0
`define USP_MODE_UART8     2'h1
`define USP_MODE_UART9F    2'h2
`define USP_MODE_UART9V    2'h3

// Last sample tick of each bit in the asynchronous modes (16 ticks a bit) and the midpoint tick.
`define USP_OVERSAMPLE_MAX 4'hF
`define USP_MID_TICK       4'h7
// Fixed 9-bit mode: clocks per sample tick, plain and doubled (32/16 and 16/16).
`define USP_FIX_DIV_PLAIN  2'h2
`define USP_FIX_DIV_DOUBLE 2'h1

`endif

// >>> hw/usp_uart.v
// Serial port with a half-duplex shift-register mode and full-duplex asynchronous modes.
`timescale 1ns/100ps
`default_nettype none
`include "usp_defs.vh"

module usp_uart (
  input  wire       i_clk,
  input  wire       i_rstn,
  input  wire [7:0] i_sfr_addr,
  input  wire       i_sfr_wr,
  input  wire [7:0] i_sfr_wdata,
  input  wire       i_sfr_rd,
  input  wire       i_bit_wr,
  input  wire [2:0] i_bit_sel,
  input  wire       i_bit_val,
  output wire [7:0] o_sfr_rdata,
  output wire       o_tx_ready,
  input  wire       i_rate_double,
  input  wire       i_baud_tick,
  input  wire       i_rxd,
  output wire       o_rxd_out,
  output wire       o_rxd_oe,
  output wire       o_txd
);

  // How the port behaves as a whole.
  // The transmitter and the receiver keep separate state, so in the asynchronous modes a frame can go out while another comes in.
  // Writes to the data address go into a two-entry transmit buffer in front of the transmit shifter.
  // A write while the buffer is full is dropped, so software must watch o_tx_ready before writing.
  // Reads of the data address return the receive holding register, which is separate from the shifter.
  // A new accepted character replaces the held one whether or not it was read; the older one is lost.
  // The receive pin passes two flip-flops before any logic reads it, which costs two clocks of latency.
  // In the asynchronous modes that latency only shifts the sampling point by a fixed amount.
  // In shift-register mode the bit time is only two clocks, so the latency is a whole bit; the receiver
  // runs one extra clock pair with the shift clock held high to collect the last bit.
  // The receive flag therefore comes two clocks later in shift-mode reception; the shift clock is not delayed.
  // Hardware sets of the flags win over a software clear in the same cycle, so no event is ever missed.
  // The stop bit is checked only in 8-bit mode with multiprocessor filtering enabled, so a framing fault
  // otherwise still delivers the character; in 8-bit mode software that cares must check the latched stop bit.

  // Receive state codes.
  localparam [2:0] RX_IDLE  = 3'h0;
  localparam [2:0] RX_START = 3'h1;
  localparam [2:0] RX_DATA  = 3'h2;
  localparam [2:0] RX_STOP  = 3'h3;
  localparam [2:0] RX_SHIFT = 3'h4;
  // Transmit state codes.
  localparam [1:0] TX_IDLE  = 2'h0;
  localparam [1:0] TX_ASYNC = 2'h1;
  localparam [1:0] TX_SHIFT = 2'h2;

  reg  [7:0] ctrl_reg;
  reg  [7:0] rdata_reg;
  reg  [7:0] rx_hold_reg;
  reg        rxd_s1_reg;
  reg        rxd_s2_reg;
  reg        rxd_prev_reg;
  reg  [1:0] div_reg;
  reg        ph_reg;
  reg  [7:0] fifo_mem [0:1];
  reg        wptr_reg;
  reg        rptr_reg;
  reg  [1:0] fcnt_reg;
  reg  [1:0] tx_state_reg;
  reg  [10:0] tx_sh_reg;
  reg  [3:0] tx_idx_reg;
  reg  [3:0] tx_cnt_reg;
  reg  [2:0] rx_state_reg;
  reg  [8:0] rx_sh_reg;
  reg  [3:0] rx_idx_reg;
  reg  [3:0] rx_cnt_reg;

  wire [1:0] mode      = {ctrl_reg[`USP_BIT_MODE_HI], ctrl_reg[`USP_BIT_MODE_LO]}; // [R6]
  wire       mode_sh   = (mode == `USP_MODE_SHIFT);
  wire       nine_bit  = mode[1];
  wire       mpen      = ctrl_reg[`USP_BIT_MPEN]; // [R10]
  wire       ren       = ctrl_reg[`USP_BIT_REN]; // [R14]
  wire       ri        = ctrl_reg[`USP_BIT_RXDONE];
  wire       rxd       = rxd_s2_reg;

  // Data address write fills transmit, read returns receive holding register.
  wire       data_wr   = i_sfr_wr && (i_sfr_addr == `USP_ADDR_DATA); // [R4]
  wire       ctrl_wr   = i_sfr_wr && (i_sfr_addr == `USP_ADDR_CTRL); // [R5]

  // Two-entry transmit buffer; a write while full is dropped, so software watches o_tx_ready.
  wire       fifo_full  = (fcnt_reg == 2'h2);
  wire       fifo_valid = (fcnt_reg != 2'h0);
  wire       push       = data_wr && !fifo_full;
  wire       tx_start   = (tx_state_reg == TX_IDLE) && fifo_valid &&
                          !(mode_sh && (rx_state_reg == RX_SHIFT));
  wire       pop        = tx_start;
  assign o_tx_ready = !fifo_full;

  // Sample tick: fixed mode divides the core clock, variable modes follow the rate source.
  wire [1:0] fix_div = i_rate_double ? `USP_FIX_DIV_DOUBLE : `USP_FIX_DIV_PLAIN; // [R8]
  wire       s_tick  = (mode == `USP_MODE_UART9F) ? (div_reg == 2'h0) : i_baud_tick; // [R9]

  // Shift-register mode phase: low half then high half of each clock/2 bit.
  wire       sh_busy = (tx_state_reg == TX_SHIFT) || (rx_state_reg == RX_SHIFT);

  // Receive completion and acceptance checks.
  wire       rx_done_async = (rx_state_reg == RX_STOP) && s_tick && (rx_cnt_reg == `USP_OVERSAMPLE_MAX);
  // Shift-mode receive: the sample taken in clock pair n holds bit n-1, because the pin arrives two
  // flip-flops late, so pair 8 runs without a clock pulse and brings in the last bit.
  wire       rx_done_sh    = (rx_state_reg == RX_SHIFT) && ph_reg && (rx_idx_reg == 4'h8);
  wire       sh_clk_on     = (tx_state_reg == TX_SHIFT) || ((rx_state_reg == RX_SHIFT) && (rx_idx_reg != 4'h8));
  wire [7:0] rx_data_async = nine_bit ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
  wire       rx_ninth      = nine_bit ? rx_sh_reg[8] : rxd; // [R17]
  wire       rx_accept     = !mpen || rx_ninth; // [R11] [R12] [R13]
  wire       rx_set        = rx_done_sh || (rx_done_async && rx_accept); // [R16]

  // Transmit flag events.
  wire [3:0] tx_last  = nine_bit ? 4'hA : 4'h9;
  wire       tx_bitend = (tx_state_reg == TX_ASYNC) && s_tick && (tx_cnt_reg == `USP_OVERSAMPLE_MAX);
  wire       tx_set   = (tx_bitend && (tx_idx_reg == tx_last - 4'h1)) ||
                        ((tx_state_reg == TX_SHIFT) && ph_reg && (tx_idx_reg == 4'h7)); // [R15]

  // Pin synchroniser, edge history and tick divider.
  // The edge history compares the second flip-flop with a third one, never the first, so a
  // metastable first stage cannot fake a start bit. All three reset high to match the idle line.
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      rxd_s1_reg   <= 1'b1;
      rxd_s2_reg   <= 1'b1;
      rxd_prev_reg <= 1'b1;
      div_reg      <= 2'h0;
      ph_reg       <= 1'b0;
    end else begin
      rxd_s1_reg   <= i_rxd;
      rxd_s2_reg   <= rxd_s1_reg;
      rxd_prev_reg <= rxd_s2_reg;
      ph_reg       <= sh_busy ? ~ph_reg : 1'b0; // [R7]
      if (div_reg == 2'h0 || div_reg >= fix_div) begin
        div_reg <= fix_div - 2'h1;
      end else begin
        div_reg <= div_reg - 2'h1;
      end
    end
  end

  // Control register: byte and bit writes; hardware sets win over software clears.
  // The hardware updates are written after the software ones so that they take priority when both
  // fall in one cycle; a flag cleared by software in the cycle of its event therefore stays set.
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      ctrl_reg <= `USP_CTRL_RESET; // [R5]
    end else begin
      if (ctrl_wr) begin
        ctrl_reg <= i_sfr_wdata;
      end else if (i_bit_wr) begin
        ctrl_reg[i_bit_sel] <= i_bit_val; // [R5]
      end
      if (rx_done_async && rx_accept) begin
        ctrl_reg[`USP_BIT_RXNINE] <= rx_ninth; // [R17]
      end
      if (rx_set) begin
        ctrl_reg[`USP_BIT_RXDONE] <= 1'b1; // [R16]
      end
      if (tx_set) begin
        ctrl_reg[`USP_BIT_TXDONE] <= 1'b1; // [R15]
      end
    end
  end

  // Registered read data, one cycle after the read strobe.
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      rdata_reg <= 8'h00;
    end else if (i_sfr_rd) begin
      if (i_sfr_addr == `USP_ADDR_CTRL) begin
        rdata_reg <= ctrl_reg;
      end else if (i_sfr_addr == `USP_ADDR_DATA) begin
        rdata_reg <= rx_hold_reg; // [R4]
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end
  assign o_sfr_rdata = rdata_reg;

  // Transmit buffer storage and pointers.
  // The storage has no reset: an entry is only read after it has been written, so its reset value
  // would never be seen, and leaving it out keeps the array free of a reset path.
  always @(posedge i_clk) begin
    if (!i_rstn) begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      fcnt_reg <= 2'h0;
    end else begin
      if (push) begin
        fifo_mem[wptr_reg] <= i_sfr_wdata;
        wptr_reg           <= ~wptr_reg;
      end
      if (pop) begin
        rptr_reg <= ~rptr_reg;
      end
      if (push && !pop) begin
        fcnt_reg <= fcnt_reg + 2'h1;
      end else if (pop && !push) begin
        fcnt_reg <= fcnt_reg - 2'h1;
      end
    end
  end

  // Transmitter; runs on its own state, but in shift mode it waits for a shift-mode reception to end.
  always @(posedge i_clk) begin // [R1]
    if (!i_rstn) begin
      tx_state_reg <= TX_IDLE;
      tx_sh_reg    <= 11'h7FF;
      tx_idx_reg   <= 4'h0;
      tx_cnt_reg   <= 4'h0;
    end else begin
      case (tx_state_reg)
        TX_IDLE: begin
          tx_idx_reg <= 4'h0;
          tx_cnt_reg <= 4'h0;
          if (tx_start) begin
            if (mode_sh) begin
              tx_sh_reg    <= {3'h7, fifo_mem[rptr_reg]};
              tx_state_reg <= TX_SHIFT;
            end else begin
              // Stop bit and, in 9-bit modes, the programmed ninth bit follow the data.
              tx_sh_reg    <= {1'b1, nine_bit ? ctrl_reg[`USP_BIT_TXNINE] : 1'b1, fifo_mem[rptr_reg], 1'b0};
              tx_state_reg <= TX_ASYNC;
            end
          end
        end
        TX_ASYNC: begin
          if (s_tick) begin
            tx_cnt_reg <= tx_cnt_reg + 4'h1;
          end
          if (tx_bitend) begin
            tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
            tx_idx_reg <= tx_idx_reg + 4'h1;
            if (tx_idx_reg == tx_last) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        TX_SHIFT: begin
          if (ph_reg) begin
            tx_sh_reg  <= {1'b1, tx_sh_reg[10:1]};
            tx_idx_reg <= tx_idx_reg + 4'h1;
            if (tx_idx_reg == 4'h7) begin
              tx_state_reg <= TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // Receiver: shifter plus separate holding register, so a new frame may arrive unread.
  always @(posedge i_clk) begin // [R2]
    if (!i_rstn) begin
      rx_state_reg <= RX_IDLE;
      rx_sh_reg    <= 9'h000;
      rx_idx_reg   <= 4'h0;
      rx_cnt_reg   <= 4'h0;
      rx_hold_reg  <= 8'h00;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          rx_idx_reg <= 4'h0;
          rx_cnt_reg <= 4'h0;
          if (mode_sh) begin
            // Shift mode waits for an empty flag and no transmit in flight.
            if (ren && !ri && (tx_state_reg == TX_IDLE) && !fifo_valid) begin // [R18]
              rx_state_reg <= RX_SHIFT;
            end
          end else if (ren && rxd_prev_reg && !rxd) begin // [R18] [R19]
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (s_tick) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == `USP_MID_TICK) begin
              // A start bit that is high again at its middle was a glitch.
              rx_state_reg <= rxd ? RX_IDLE : RX_DATA;
              rx_cnt_reg   <= 4'h0;
            end
          end
        end
        RX_DATA: begin
          if (s_tick) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
            if (rx_cnt_reg == `USP_OVERSAMPLE_MAX) begin
              rx_sh_reg  <= {rxd, rx_sh_reg[8:1]};
              rx_idx_reg <= rx_idx_reg + 4'h1;
              if (rx_idx_reg == (nine_bit ? 4'h8 : 4'h7)) begin
                rx_state_reg <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (s_tick) begin
            rx_cnt_reg <= rx_cnt_reg + 4'h1;
          end
          if (rx_done_async) begin
            if (rx_accept) begin
              rx_hold_reg <= rx_data_async; // [R3]
            end
            rx_state_reg <= RX_IDLE;
          end
        end
        RX_SHIFT: begin
          // Sample on the rising half of the shift clock, LSB first.
          // The first sample is the pin before the first clock pulse and ends up in bit 1 of the
          // shifter, where the final load below leaves it out.
          if (ph_reg) begin
            rx_sh_reg  <= {rxd, rx_sh_reg[8:1]};
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_done_sh) begin
              rx_hold_reg  <= {rxd, rx_sh_reg[8:2]}; // [R3]
              rx_state_reg <= RX_IDLE;
            end
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // Pins: shift mode drives data on the receive pin and the clock on the transmit pin.
  // The data pin is driven only while transmitting, so in shift-mode reception the far side owns it.
  // The shift clock stays high during the extra receive pair, so the far side sees exactly eight pulses.
  assign o_rxd_oe  = (tx_state_reg == TX_SHIFT);
  assign o_rxd_out = (tx_state_reg == TX_SHIFT) ? tx_sh_reg[0] : 1'b1;
  assign o_txd     = mode_sh ? (sh_clk_on ? ph_reg : 1'b1)
                             : ((tx_state_reg == TX_ASYNC) ? tx_sh_reg[0] : 1'b1); // [R19]

endmodule // usp_uart
`default_nettype wire

// >>> tb/usp_uart_monitor.sv
// Checker for the serial port pins and register bus.
`timescale 1ns/100ps
`default_nettype none
module usp_uart_monitor (
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic [7:0] i_sfr_addr,
  input wire logic       i_sfr_wr,
  input wire logic [7:0] i_sfr_wdata,
  input wire logic       i_sfr_rd,
  input wire logic       i_bit_wr,
  input wire logic [2:0] i_bit_sel,
  input wire logic       i_bit_val,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic       o_tx_ready,
  input wire logic       i_rate_double,
  input wire logic       i_baud_tick,
  input wire logic       i_rxd,
  input wire logic       o_rxd_out,
  input wire logic       o_rxd_oe,
  input wire logic       o_txd
);
  logic [4:0] ctrl_hi_reg;
  wire  [1:0] mode_w = ctrl_hi_reg[4:3];
  // Shadow of software-owned control bits, so mode-dependent checks know the mode.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) ctrl_hi_reg <= 5'h00;
    else if (i_sfr_wr && i_sfr_addr == 8'h98) ctrl_hi_reg <= i_sfr_wdata[7:3];
    else if (i_bit_wr && i_bit_sel >= 3'h3) ctrl_hi_reg[i_bit_sel - 3'h3] <= i_bit_val;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_reset_idle: assert property ($rose(i_rstn) |-> o_txd && o_tx_ready && !o_rxd_oe && o_sfr_rdata == 8'h00)
    else $error("idle state wrong after reset");
  a_unmapped_read: assert property (i_sfr_rd && i_sfr_addr != 8'h98 && i_sfr_addr != 8'h99 |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!i_sfr_rd |=> $stable(o_sfr_rdata))
    else $error("read data moved without a read");
  a_ctrl_readback: assert property (i_sfr_rd && i_sfr_addr == 8'h98 && !i_sfr_wr && !i_bit_wr
    |=> o_sfr_rdata[7:3] == $past(ctrl_hi_reg)) else $error("control read back wrong");
  a_shift_clock: assert property (mode_w == 2'h0 && $fell(o_txd) |=> o_txd)
    else $error("shift clock low too long");
  a_async_bit: assert property (mode_w != 2'h0 && $fell(o_txd) |-> !o_txd [*8])
    else $error("async low bit too short");
  a_oe_mode: assert property (o_rxd_oe |-> mode_w == 2'h0)
    else $error("data pin driven outside shift mode");
  a_ready_fall: assert property ($fell(o_tx_ready) |-> $past(i_sfr_wr) && $past(i_sfr_addr) == 8'h99)
    else $error("buffer filled without a data write");
endmodule // usp_uart_monitor
bind usp_uart usp_uart_monitor u_usp_uart_monitor (.i_clk(i_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr),
  .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd), .i_bit_wr(i_bit_wr),
  .i_bit_sel(i_bit_sel), .i_bit_val(i_bit_val), .o_sfr_rdata(o_sfr_rdata), .o_tx_ready(o_tx_ready),
  .i_rate_double(i_rate_double), .i_baud_tick(i_baud_tick), .i_rxd(i_rxd), .o_rxd_out(o_rxd_out),
  .o_rxd_oe(o_rxd_oe), .o_txd(o_txd));
`default_nettype wire

// >>> tb/usp_node.sv
// Remote serial node: sends asynchronous frames and decodes what the port sends.
`timescale 1ns/100ps
`default_nettype none
module usp_node (
  input  wire logic i_clk,
  input  wire logic i_txd,
  input  wire logic i_rxd_out,
  output var  logic o_rxd
);
  // Idle high so the port never sees a false start bit.
  initial o_rxd = 1'b1;
  // Start bit, nb bits LSB first, then a stop bit; per is clocks per bit.
  task automatic send(input logic [8:0] d, input int nb, input int per);
    for (int i = -1; i <= nb; i++) begin
      o_rxd = (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : d[i];
      repeat (per) @(negedge i_clk);
    end
    repeat (8) @(negedge i_clk);
  endtask
  // Samples at mid-bit; b gets the nb bits and then the stop bit.
  task automatic recv(input int nb, input int per, output logic [9:0] b);
    b = 10'h000;
    @(negedge i_txd);
    repeat (per / 2) @(negedge i_clk);
    for (int i = 0; i <= nb; i++) begin
      repeat (per) @(negedge i_clk);
      b[i] = i_txd;
    end
  endtask
  // Shift mode receive by the port: each bit goes out as the shift clock falls.
  task automatic send0(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge i_txd);
      o_rxd = d[i];
    end
    repeat (4) @(negedge i_clk);
    o_rxd = 1'b1;
  endtask
  // Shift mode: data is read while the shift clock is high, where it is steady.
  task automatic recv0(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(posedge i_txd);
      @(negedge i_clk);
      b[i] = i_rxd_out;
    end
  endtask
endmodule // usp_node
`default_nettype wire

// >>> tb/usp_uart_tb_top.sv
// Testbench for the serial port.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH %0t got %h exp %h", $time, (a), (e)); end end
module usp_uart_tb_top;
  logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, bw = 1'b0, bval = 1'b0, dbl = 1'b0, tick = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [2:0] bsel = 3'h0;
  wire        rxd_w, rxd_out, oe, txd, ready, node_rxd;
  wire  [7:0] rdata;
  int         errors = 0, check_count = 0;
  // Clock and a sample tick every second clock, so an async bit is 32 clocks.
  always #2.5 clk = ~clk;
  always @(negedge clk) tick <= ~tick;
  // The port owns the data pin only while its output enable is high.
  assign rxd_w = oe ? rxd_out : node_rxd;
  usp_uart u_usp_uart (.i_clk(clk), .i_rstn(rstn), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
    .i_sfr_rd(rd), .i_bit_wr(bw), .i_bit_sel(bsel), .i_bit_val(bval), .o_sfr_rdata(rdata),
    .o_tx_ready(ready), .i_rate_double(dbl), .i_baud_tick(tick), .i_rxd(rxd_w),
    .o_rxd_out(rxd_out), .o_rxd_oe(oe), .o_txd(txd));
  usp_node u_usp_node (.i_clk(clk), .i_txd(txd), .i_rxd_out(rxd_out), .o_rxd(node_rxd));
  // Bus tasks start at a falling edge and leave one idle cycle, so strobes never retrigger.
  task automatic wr8(input logic [7:0] a, d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic bit8(input logic [2:0] s, input logic v);
    bsel = s;
    bval = v;
    bw = 1'b1;
    @(negedge clk);
    bw = 1'b0;
    @(negedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, e);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  task automatic close_out();
    if (errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Every mode code reads back; a bit write sets the receiver enable.
  task automatic t_regs();
    rchk(8'h98, 8'h00);
    `CHK({txd, ready, oe}, 3'b110)
    for (int m = 0; m < 4; m++) begin
      wr8(8'h98, {m[1:0], 6'h20});
      rchk(8'h98, {m[1:0], 6'h20});
    end
    bit8(3'h4, 1'b1);
    rchk(8'h98, 8'hF0);
    rchk(8'h97, 8'h00);
  endtask
  // Shift mode sends LSB first, then raises the transmit flag.
  task automatic t_shift();
    logic [7:0] b;
    wr8(8'h98, 8'h00);
    fork
      u_usp_node.recv0(b);
      wr8(8'h99, 8'h5A);
    join
    repeat (4) @(negedge clk);
    `CHK(b, 8'h5A)
    rchk(8'h98, 8'h02);
    wr8(8'h98, 8'h50);
  endtask
  // Shift mode reception starts on enable with the flag clear and raises the receive flag.
  task automatic t_shift_rx();
    fork
      u_usp_node.send0(8'hC3);
      wr8(8'h98, 8'h10);
    join
    repeat (4) @(negedge clk);
    rchk(8'h99, 8'hC3);
    rchk(8'h98, 8'h11);
    wr8(8'h98, 8'h50);
  endtask
  // Send and receive at once; the stop bit lands in the received ninth bit.
  task automatic t_duplex();
    logic [9:0] b;
    fork
      u_usp_node.send(9'h03C, 8, 32);
      u_usp_node.recv(8, 32, b);
      wr8(8'h99, 8'hA5);
    join
    `CHK(b, 10'h1A5)
    rchk(8'h98, 8'h57);
    rchk(8'h99, 8'h3C);
  endtask
  // Fill the buffer until it refuses; the slow node drains it in order.
  task automatic t_buffer();
    logic [9:0] b;
    logic [7:0] e8;
    logic [7:0] q[$];
    fork
      begin
        for (int i = 1; i < 6 && ready; i++) begin
          q.push_back({i[3:0], i[3:0]});
          wr8(8'h99, {i[3:0], i[3:0]});
        end
        `CHK(ready, 1'b0)
      end
      do begin
        u_usp_node.recv(8, 32, b);
        e8 = q.pop_front();
        `CHK(b[7:0], e8)
      end while (q.size() > 0);
    join
  endtask
  // Two unread characters leave only the newer one.
  task automatic t_overrun();
    wr8(8'h98, 8'h50);
    u_usp_node.send(9'h011, 8, 32);
    u_usp_node.send(9'h022, 8, 32);
    rchk(8'h99, 8'h22);
  endtask
  // Filtering drops a zero ninth bit; with filtering off every frame is taken.
  task automatic t_filter();
    wr8(8'h98, 8'hF0);
    u_usp_node.send(9'h077, 9, 32);
    rchk(8'h98, 8'hF0);
    u_usp_node.send(9'h166, 9, 32);
    rchk(8'h98, 8'hF5);
    rchk(8'h99, 8'h66);
    wr8(8'h98, 8'hD0);
    u_usp_node.send(9'h044, 9, 32);
    rchk(8'h98, 8'hD1);
  endtask
  // Fixed-rate mode: 32 clocks a bit, 16 when doubled; ninth bit from the control register.
  task automatic t_fixed();
    logic [9:0] b;
    wr8(8'h98, 8'h88);
    for (int k = 0; k < 2; k++) begin
      dbl = k[0];
      fork
        u_usp_node.recv(9, 32 >> k, b);
        wr8(8'h99, 8'h55);
      join
      `CHK(b, 10'h355)
    end
  endtask
  // Main sequence after four reset cycles.
  initial begin
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    t_regs();
    t_shift();
    t_shift_rx();
    t_duplex();
    t_buffer();
    t_overrun();
    t_filter();
    t_fixed();
    close_out();
  end
  // Watchdog: the run needs under 4000 cycles, so 20000 means a hang.
  initial begin
    #100000;
    errors++;
    close_out();
  end
endmodule // usp_uart_tb_top
`default_nettype wire
